//--- core/ssrm_pkg.sv
package ssrm_pkg;

  // item widths on the map
  typedef logic [15:0] ssrm_uint_t;
  typedef logic [31:0] ssrm_unsigned_double_integer_t;
  typedef logic [15:0] ssrm_word_t;
  typedef logic [31:0] ssrm_dword_t;
  typedef logic [7:0]  ssrm_byte_t;

  typedef enum logic [7:0] {
    SSRM_MODE_NORMAL     = 8'h01,
    SSRM_MODE_CONFIG     = 8'h02,
    SSRM_MODE_LOCKOUT    = 8'h04,
    SSRM_MODE_WAIT_RESET = 8'h41,
    SSRM_MODE_ENTER_CFG  = 8'h81
  } ssrm_mode_e;

  typedef enum logic [1:0] {
    SSRM_SP_DISC  = 2'h0,
    SSRM_SP_INPUT = 2'h1,
    SSRM_SP_HOLD  = 2'h2,
    SSRM_SP_ASM   = 2'h3
  } ssrm_space_e;

  // register numbering bases
  localparam logic [15:0] SSRM_BASE_INPUT = 16'h7530;
  localparam logic [15:0] SSRM_BASE_HOLD  = 16'h9C40;

  // word map, same for input and holding registers
  localparam int SSRM_NUM_VSO   = 16;
  localparam int SSRM_STR_WORDS = 8;
  localparam int SSRM_STR_CHARS = 16;
  localparam logic [15:0] SSRM_REG_MODE    = 16'h0000;
  localparam logic [15:0] SSRM_REG_VSO     = 16'h0001;
  localparam logic [15:0] SSRM_REG_FLAG    = 16'h0002;
  localparam logic [15:0] SSRM_REG_SECS_HI = 16'h0003;
  localparam logic [15:0] SSRM_REG_SECS_LO = 16'h0004;
  localparam logic [15:0] SSRM_REG_IP_HI   = 16'h0006;
  localparam logic [15:0] SSRM_REG_IP_LO   = 16'h0007;
  localparam logic [15:0] SSRM_REG_LEN_HI  = 16'h0008;
  localparam logic [15:0] SSRM_REG_LEN_LO  = 16'h0009;
  localparam logic [15:0] SSRM_REG_STR     = 16'h000A;
  localparam logic [15:0] SSRM_REG_FIDX    = 16'h0018;
  localparam logic [15:0] SSRM_REG_FTS     = 16'h0028;
  localparam logic [15:0] SSRM_PAD_WORD    = 16'h0000;
  localparam logic [15:0] SSRM_FAULT_SCALE = 16'h0064;

  // client register offsets
  localparam logic [3:0] SSRM_C_CMD    = 4'h0;
  localparam logic [3:0] SSRM_C_CTRL   = 4'h1;
  localparam logic [3:0] SSRM_C_STATUS = 4'h2;
  localparam logic [3:0] SSRM_C_RESULT = 4'h3;
  localparam logic [3:0] SSRM_C_FAULT  = 4'h4;
  localparam logic [3:0] SSRM_C_OCTET  = 4'h5;
  localparam logic [3:0] SSRM_C_HEX_HI = 4'h6;
  localparam logic [3:0] SSRM_C_HEX_LO = 4'h7;
  localparam int SSRM_CMD_BIT_LSB = 16;
  localparam int SSRM_CMD_ASM     = 20;
  localparam int SSRM_CMD_W       = 21;

  localparam logic [7:0] SSRM_ASCII_SPACE = 8'h20;
  localparam logic [7:0] SSRM_ASCII_ZERO  = 8'h30;
  localparam logic [7:0] SSRM_ASCII_ALPHA = 8'h37;

  // timing
  localparam int SSRM_CLK_NS        = 8;
  localparam int SSRM_SEC_NS        = 1_000_000_000;
  localparam int SSRM_POLL_NS       = 10_000_000;
  localparam int SSRM_TICKS_PER_SEC = SSRM_SEC_NS / SSRM_CLK_NS;
  localparam int SSRM_POLL_CYCLES   = SSRM_POLL_NS / SSRM_CLK_NS;

endpackage

//--- core/ssrm_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ssrm_link_if;
  import ssrm_pkg::*;
  logic        req;
  ssrm_space_e space;
  logic [15:0] addr;
  logic        ack;
  logic [15:0] rdata;
  modport device (input req, input space, input addr, output ack, output rdata);
  modport client (output req, output space, output addr, input ack, input rdata);
endinterface
`default_nettype wire

//--- core/ssrm_sec_counter.sv
`timescale 1ns/1ps
`default_nettype none
module ssrm_sec_counter import ssrm_pkg::*; #(
  parameter int TICKS_PER_SEC = SSRM_TICKS_PER_SEC
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // whole seconds since reset
  output logic [31:0]      seconds_out
);

  localparam int PW = (TICKS_PER_SEC > 1) ? $clog2(TICKS_PER_SEC) : 1;
  localparam logic [PW-1:0] LAST = PW'(TICKS_PER_SEC - 1);

  logic [PW-1:0] pre_q;

  always_ff @(posedge clk_in) begin
    if (rst_in || pre_q == LAST) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + PW'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      seconds_out <= '0;
    end else if (pre_q == LAST) begin
      seconds_out <= seconds_out + 32'h0000_0001;
    end
  end

endmodule // ssrm_sec_counter
`default_nettype wire

//--- core/ssrm_device.sv
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ssrm_device import ssrm_pkg::*; #(
  parameter int NVSO          = SSRM_NUM_VSO,
  parameter int TICKS_PER_SEC = SSRM_TICKS_PER_SEC
) (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  // network side
  ssrm_link_if.device            link,
  // virtual status outputs and faults
  input  wire logic [NVSO-1:0]   vso_state_in,
  input  wire logic [NVSO-1:0]   fault_set_in,
  input  wire logic [NVSO-1:0]   fault_clear_in,
  input  wire logic [7:0]        fault_major_in,
  input  wire logic [7:0]        fault_minor_in,
  // controller state and settings
  input  wire ssrm_mode_e        mode_in,
  input  wire logic              len16_in,
  input  wire logic              swap_in,
  input  wire logic [31:0]       ip_addr_in,
  // string contents
  input  wire logic              str_wr_in,
  input  wire logic [3:0]        str_idx_in,
  input  wire logic [7:0]        str_char_in,
  input  wire logic [31:0]       str_len_in,
  // status
  output logic [NVSO-1:0]        fault_flag_out,
  output logic [31:0]            seconds_out
);

  logic [15:0]  fidx_q [NVSO];
  logic [31:0]  fts_q  [NVSO];
  logic [7:0]   str_q  [SSRM_STR_CHARS];
  ssrm_mode_e   mode_q;
  logic [15:0]  code_d;
  logic [15:0]  vso16;
  logic [15:0]  flag16;
  logic [15:0]  widx;
  logic [15:0]  off;
  logic [15:0]  word_d;
  logic         bit_d;
  logic [15:0]  rdata_q;
  logic         ack_q;

  ssrm_sec_counter #(
    .TICKS_PER_SEC (TICKS_PER_SEC)
  ) ssrm_sec_counter_i (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .seconds_out (seconds_out)
  );

  assign code_d = 16'(fault_major_in) * SSRM_FAULT_SCALE + 16'(fault_minor_in);

  genvar g;
  generate
    for (g = 0; g < NVSO; g++) begin : g_vso
      // a new fault in the clear cycle keeps the flag and takes a fresh entry
      logic take;
      assign take = fault_set_in[g] && (!fault_flag_out[g] || fault_clear_in[g]);

      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          fault_flag_out[g] <= 1'b0;
        end else if (fault_set_in[g]) begin
          fault_flag_out[g] <= 1'b1;
        end else if (fault_clear_in[g]) begin
          fault_flag_out[g] <= 1'b0;
        end
      end

      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          fidx_q[g] <= '0;
        end else if (take) begin
          fidx_q[g] <= code_d;
        end else if (fault_clear_in[g]) begin
          fidx_q[g] <= '0;
        end
      end

      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          fts_q[g] <= '0;
        end else if (take) begin
          fts_q[g] <= seconds_out;
        end
      end
    end
  endgenerate

  // only the five legal codes are accepted; anything else keeps the last one
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_q <= SSRM_MODE_NORMAL;
    end else begin
      case (mode_in)
        SSRM_MODE_NORMAL, SSRM_MODE_CONFIG, SSRM_MODE_LOCKOUT,
        SSRM_MODE_WAIT_RESET, SSRM_MODE_ENTER_CFG: mode_q <= mode_in;
        default: mode_q <= mode_q;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < SSRM_STR_CHARS; i++) begin
        str_q[i] <= '0;
      end
    end else if (str_wr_in) begin
      str_q[str_idx_in] <= str_char_in;
    end
  end

  always_comb begin
    vso16 = '0;
    flag16 = '0;
    vso16[NVSO-1:0] = vso_state_in;
    flag16[NVSO-1:0] = fault_flag_out;
  end

  // assembly bytes address words two at a time
  assign widx = (link.space == SSRM_SP_ASM) ? {1'b0, link.addr[15:1]} : link.addr;

  always_comb begin
    word_d = '0;
    off = '0;
    if (widx == SSRM_REG_MODE) begin
      word_d = {8'h00, mode_q};
    end else if (widx == SSRM_REG_VSO) begin
      word_d = vso16;
    end else if (widx == SSRM_REG_FLAG) begin
      word_d = flag16;
    end else if (widx == SSRM_REG_SECS_HI) begin
      word_d = seconds_out[31:16];
    end else if (widx == SSRM_REG_SECS_LO) begin
      word_d = seconds_out[15:0];
    end else if (widx == SSRM_REG_IP_HI) begin
      word_d = ip_addr_in[31:16];
    end else if (widx == SSRM_REG_IP_LO) begin
      word_d = ip_addr_in[15:0];
    end else if (widx == SSRM_REG_LEN_HI) begin
      word_d = len16_in ? SSRM_PAD_WORD : str_len_in[31:16];
    end else if (widx == SSRM_REG_LEN_LO) begin
      word_d = str_len_in[15:0];
    end else if (widx >= SSRM_REG_STR && widx < SSRM_REG_STR + 16'(SSRM_STR_WORDS)) begin
      off = widx - SSRM_REG_STR;
      // first character in the high byte unless swapped
      word_d = swap_in ? {str_q[{off[2:0], 1'b1}], str_q[{off[2:0], 1'b0}]}
                       : {str_q[{off[2:0], 1'b0}], str_q[{off[2:0], 1'b1}]};
    end else if (widx >= SSRM_REG_FIDX && widx < SSRM_REG_FIDX + 16'(NVSO)) begin
      off = widx - SSRM_REG_FIDX;
      word_d = fidx_q[off[3:0]];
    end else if (widx >= SSRM_REG_FTS && widx < SSRM_REG_FTS + 16'(2 * NVSO)) begin
      off = widx - SSRM_REG_FTS;
      word_d = off[0] ? fts_q[off[4:1]][15:0] : fts_q[off[4:1]][31:16];
    end
  end

  // reserved and unmapped locations answer zero
  always_comb begin
    bit_d = 1'b0;
    if (link.addr < 16'(NVSO)) begin
      bit_d = vso_state_in[link.addr[3:0]];
    end else if (link.addr < 16'(2 * NVSO)) begin
      bit_d = fault_flag_out[4'(link.addr - 16'(NVSO))];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_q <= '0;
    end else if (link.req) begin
      case (link.space)
        SSRM_SP_DISC:  rdata_q <= {15'h0000, bit_d};
        SSRM_SP_ASM:   rdata_q <= {8'h00, link.addr[0] ? word_d[15:8] : word_d[7:0]};
        default:       rdata_q <= word_d;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= link.req;
    end
  end

  assign link.rdata = rdata_q;
  assign link.ack = ack_q;

endmodule // ssrm_device
`default_nettype wire

//--- core/ssrm_client.sv
`timescale 1ns/1ps
`default_nettype none
module ssrm_client import ssrm_pkg::*; #(
  parameter int POLL_CYCLES = SSRM_POLL_CYCLES
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // network side
  ssrm_link_if.client       link,
  // software port
  input  wire logic [3:0]   addr_in,
  input  wire logic [31:0]  wdata_in,
  input  wire logic         wr_in,
  input  wire logic         rd_in,
  output logic [31:0]       rdata_out,
  output logic              busy_out
);

  typedef enum logic [1:0] {
    SSRM_ST_IDLE  = 2'b00,
    SSRM_ST_ISSUE = 2'b01,
    SSRM_ST_WAIT  = 2'b11
  } ssrm_state_e;

  ssrm_state_e             state_q;
  logic [SSRM_CMD_W-1:0]   cmd_q;
  logic [SSRM_CMD_W-1:0]   cmd_d;
  logic                    cyclic_q;
  logic [31:0]             timer_q;
  logic                    start;
  ssrm_space_e             space_q;
  logic [15:0]             addr_q;
  logic [15:0]             result_q;
  logic                    bit_q;
  logic                    done_q;
  logic [15:0]             num;

  function automatic logic [11:0] to_bcd(input logic [7:0] b);
    return {4'(b / 8'd100), 4'((b / 8'd10) % 8'd10), 4'(b % 8'd10)};
  endfunction

  function automatic logic [7:0] to_hex(input logic [3:0] n);
    return (n < 4'hA) ? SSRM_ASCII_ZERO + 8'(n) : SSRM_ASCII_ALPHA + 8'(n);
  endfunction

  assign start = (state_q == SSRM_ST_IDLE) &&
                 ((wr_in && addr_in == SSRM_C_CMD) || (cyclic_q && timer_q == '0));
  assign cmd_d = (wr_in && addr_in == SSRM_C_CMD) ? wdata_in[SSRM_CMD_W-1:0] : cmd_q;
  assign num = cmd_d[15:0];

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= SSRM_ST_IDLE;
    end else begin
      case (state_q)
        SSRM_ST_IDLE:  state_q <= start ? SSRM_ST_ISSUE : SSRM_ST_IDLE;
        SSRM_ST_ISSUE: state_q <= SSRM_ST_WAIT;
        SSRM_ST_WAIT:  state_q <= link.ack ? SSRM_ST_IDLE : SSRM_ST_WAIT;
        default:       state_q <= SSRM_ST_IDLE;
      endcase
    end
  end

  // commands written while busy are dropped
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cmd_q <= '0;
      space_q <= SSRM_SP_DISC;
      addr_q <= '0;
    end else if (start) begin
      cmd_q <= cmd_d;
      if (cmd_d[SSRM_CMD_ASM]) begin
        space_q <= SSRM_SP_ASM;
        addr_q <= num;
      end else if (num >= SSRM_BASE_HOLD) begin
        space_q <= SSRM_SP_HOLD;
        addr_q <= num - SSRM_BASE_HOLD;
      end else if (num >= SSRM_BASE_INPUT) begin
        space_q <= SSRM_SP_INPUT;
        addr_q <= num - SSRM_BASE_INPUT;
      end else begin
        space_q <= SSRM_SP_DISC;
        addr_q <= num;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cyclic_q <= 1'b0;
    end else if (wr_in && addr_in == SSRM_C_CTRL) begin
      cyclic_q <= wdata_in[0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in || start) begin
      timer_q <= 32'(POLL_CYCLES - 1);
    end else if (timer_q != '0) begin
      timer_q <= timer_q - 32'h0000_0001;
    end
  end

  // the word is stored as read; meaning is left to software, reserved words included
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      result_q <= '0;
      bit_q <= 1'b0;
    end else if (state_q == SSRM_ST_WAIT && link.ack) begin
      result_q <= link.rdata;
      bit_q <= (space_q == SSRM_SP_DISC) ? link.rdata[0]
             : (space_q == SSRM_SP_ASM) ? link.rdata[{1'b0, cmd_q[SSRM_CMD_BIT_LSB +: 3]}]
             : link.rdata[cmd_q[SSRM_CMD_BIT_LSB +: 4]];
    end
  end

  // completion beats the clear from a new command
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      done_q <= 1'b0;
    end else if (state_q == SSRM_ST_WAIT && link.ack) begin
      done_q <= 1'b1;
    end else if (start) begin
      done_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in || !rd_in) begin
      rdata_out <= '0;
    end else begin
      case (addr_in)
        SSRM_C_CMD:    rdata_out <= 32'(cmd_q);
        SSRM_C_CTRL:   rdata_out <= {31'h0, cyclic_q};
        SSRM_C_STATUS: rdata_out <= {30'h0, done_q, busy_out};
        SSRM_C_RESULT: rdata_out <= {15'h0, bit_q, result_q};
        SSRM_C_FAULT:  rdata_out <= {16'h0, 8'(result_q / SSRM_FAULT_SCALE),
                                     8'(result_q % SSRM_FAULT_SCALE)};
        SSRM_C_OCTET:  rdata_out <= {4'h0, to_bcd(result_q[15:8]), 4'h0, to_bcd(result_q[7:0])};
        SSRM_C_HEX_HI: rdata_out <= {to_hex(result_q[15:12]), to_hex(result_q[11:8]),
                                     SSRM_ASCII_SPACE, to_hex(result_q[7:4])};
        SSRM_C_HEX_LO: rdata_out <= {to_hex(result_q[3:0]), 24'h000000};
        default:       rdata_out <= '0;
      endcase
    end
  end

  assign busy_out = (state_q != SSRM_ST_IDLE);
  assign link.req = (state_q == SSRM_ST_ISSUE);
  assign link.space = space_q;
  assign link.addr = addr_q;

endmodule // ssrm_client
`default_nettype wire

//--- test/ssrm_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ssrm_link_properties import ssrm_pkg::*; (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // link signals
  input  wire logic        req,
  input  wire ssrm_space_e space,
  input  wire logic [15:0] addr,
  input  wire logic        ack,
  input  wire logic [15:0] rdata
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  logic reg_sp;
  assign reg_sp = (space == SSRM_SP_INPUT) || (space == SSRM_SP_HOLD);

  a_ack_follows: assert property (req |=> ack)
    else $error("link ack missing after request");
  a_ack_caused: assert property (ack |-> $past(req))
    else $error("link ack without request");
  a_req_single: assert property (req |=> !req)
    else $error("link request longer than one cycle");
  a_ack_single: assert property (ack |=> !ack)
    else $error("link ack longer than one cycle");
  a_req_holds: assert property (req |=> $stable(space) && $stable(addr))
    else $error("space or address moved before ack");
  // answer is registered, so it may only move in the ack cycle
  a_rdata_holds: assert property (!ack |-> $stable(rdata))
    else $error("read data moved outside ack");
  a_disc_bit: assert property (ack && space == SSRM_SP_DISC |-> rdata[15:1] == 15'h0000)
    else $error("discrete answer wider than one bit");
  a_mode_code: assert property (ack && reg_sp && addr == SSRM_REG_MODE |->
    rdata[15:8] == 8'h00 && rdata[7:0] inside {8'h01, 8'h02, 8'h04, 8'h41, 8'h81})
    else $error("mode word holds no valid code");
  a_rsv_zero: assert property (ack && reg_sp && (addr == 16'h0005 ||
    (addr >= 16'h0012 && addr <= 16'h0017)) |-> rdata == 16'h0000)
    else $error("reserved word not zero");

  c_disc_read: cover property (ack && space == SSRM_SP_DISC);
  c_mode_read: cover property (ack && reg_sp && addr == SSRM_REG_MODE);
  c_poll_pair: cover property (req ##20 req);
endmodule // ssrm_link_properties
`default_nettype wire

//--- test/safety_status_register_map_bench.sv
`timescale 1ns/1ps
`default_nettype none
module safety_status_register_map_bench import ssrm_pkg::*;;
  localparam int TPS  = 10;
  localparam int POLL = 20;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [15:0] vso    = '0;
  logic [15:0] fset   = '0;
  logic [15:0] fclr   = '0;
  logic [7:0]  fmaj   = '0;
  logic [7:0]  fmin   = '0;
  ssrm_mode_e  mode   = SSRM_MODE_NORMAL;
  logic        len16  = 1'b0;
  logic        swap   = 1'b0;
  logic [31:0] ip     = '0;
  logic        swr    = 1'b0;
  logic [3:0]  sidx   = '0;
  logic [7:0]  schar  = '0;
  logic [31:0] slen   = '0;
  logic [15:0] flags;
  logic [31:0] secs;
  logic [3:0]  a      = '0;
  logic [31:0] wd     = '0;
  logic        wr     = 1'b0;
  logic        rd     = 1'b0;
  logic [31:0] rdo;
  logic        busy;
  logic [31:0] r;
  int          n_mismatch   = 0;
  int          total_checks = 0;
  int          npoll        = 0;
  ssrm_mode_e  mv [5] = '{SSRM_MODE_CONFIG, SSRM_MODE_LOCKOUT, SSRM_MODE_WAIT_RESET,
                          SSRM_MODE_ENTER_CFG, SSRM_MODE_NORMAL};

  always #4 clk_in = ~clk_in;

  ssrm_link_if ssrm_link_if_i ();
  ssrm_device #(.NVSO(16), .TICKS_PER_SEC(TPS)) ssrm_device_i (
    .clk_in(clk_in), .rst_in(rst_in), .link(ssrm_link_if_i),
    .vso_state_in(vso), .fault_set_in(fset), .fault_clear_in(fclr),
    .fault_major_in(fmaj), .fault_minor_in(fmin), .mode_in(mode),
    .len16_in(len16), .swap_in(swap), .ip_addr_in(ip), .str_wr_in(swr),
    .str_idx_in(sidx), .str_char_in(schar), .str_len_in(slen),
    .fault_flag_out(flags), .seconds_out(secs));
  ssrm_client #(.POLL_CYCLES(POLL)) ssrm_client_i (
    .clk_in(clk_in), .rst_in(rst_in), .link(ssrm_link_if_i), .addr_in(a),
    .wdata_in(wd), .wr_in(wr), .rd_in(rd), .rdata_out(rdo), .busy_out(busy));
  ssrm_link_properties ssrm_link_properties_i (
    .clk_in(clk_in), .rst_in(rst_in), .req(ssrm_link_if_i.req),
    .space(ssrm_link_if_i.space), .addr(ssrm_link_if_i.addr),
    .ack(ssrm_link_if_i.ack), .rdata(ssrm_link_if_i.rdata));

  always @(posedge clk_in) begin
    if (ssrm_link_if_i.req === 1'b1) npoll++;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrr(input logic [3:0] ad, input logic [31:0] d);
    @(posedge clk_in);
    a <= ad;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask

  task automatic rdr(input logic [3:0] ad, output logic [31:0] d);
    @(posedge clk_in);
    a <= ad;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    // answer stands one cycle only; taken at the edge that closes it
    @(posedge clk_in);
    d = rdo;
  endtask

  // one link transfer through the client, then its result word
  task automatic q(input logic [31:0] c, output logic [31:0] res);
    logic [31:0] s;
    int k;
    wrr(SSRM_C_CMD, c);
    #1 chk("busy", {31'h0, busy}, 32'h1);
    s = '0;
    for (k = 0; k < 20 && s[1] !== 1'b1; k++) rdr(SSRM_C_STATUS, s);
    chk("done", {31'h0, s[1]}, 32'h1);
    rdr(SSRM_C_RESULT, res);
  endtask

  task automatic qc(input string nm, input logic [31:0] c, input logic [15:0] exp);
    q(c, r);
    chk(nm, {16'h0, r[15:0]}, {16'h0, exp});
  endtask

  function automatic logic [31:0] hr(input logic [15:0] off, input logic [3:0] b);
    return {12'h000, b, SSRM_BASE_HOLD + off};
  endfunction

  function automatic logic [31:0] ir(input logic [15:0] off);
    return {16'h0000, SSRM_BASE_INPUT + off};
  endfunction

  initial begin
    #200000;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (52) @(posedge clk_in);
    #1 chk("secs", secs, 32'd5);
    repeat (100) @(posedge clk_in);
    #1 chk("secs", secs, 32'd15);
    @(posedge clk_in);
    fmaj <= 8'h04;
    fmin <= 8'h0C;
    fset <= 16'h0008;
    @(posedge clk_in);
    fset <= '0;
    #1 chk("flag", {16'h0, flags}, 32'h0008);
    qc("fidx", hr(SSRM_REG_FIDX + 16'h3, 4'h0), 16'd412);
    rdr(SSRM_C_FAULT, r);
    chk("fcode", r, 32'h0000_040C);
    qc("fidx_clear", hr(SSRM_REG_FIDX + 16'h2, 4'h0), 16'h0000);
    qc("flag_word", ir(SSRM_REG_FLAG), 16'h0008);
    q(hr(SSRM_REG_FLAG, 4'h3), r);
    chk("flag_bit", {31'h0, r[16]}, 32'h1);
    qc("flag_disc", 32'd19, 16'h0001);
    qc("ts_hi", hr(SSRM_REG_FTS + 16'h6, 4'h0), 16'h0000);
    qc("ts_lo", hr(SSRM_REG_FTS + 16'h7, 4'h0), 16'd15);
    qc("secs_hi", ir(SSRM_REG_SECS_HI), 16'h0000);
    fclr <= 16'h0008;
    @(posedge clk_in);
    fclr <= '0;
    qc("fidx_off", hr(SSRM_REG_FIDX + 16'h3, 4'h0), 16'h0000);
    chk("flag_off", {16'h0, flags}, 32'h0);
    // set and clear in one cycle: the new fault wins
    fmaj <= 8'h02;
    fmin <= 8'h01;
    fset <= 16'h0008;
    fclr <= 16'h0008;
    @(posedge clk_in);
    fset <= '0;
    fclr <= '0;
    qc("fidx_both", hr(SSRM_REG_FIDX + 16'h3, 4'h0), 16'd201);
    chk("flag_both", {16'h0, flags}, 32'h0008);
    foreach (mv[k]) begin
      mode <= mv[k];
      qc("mode", (k % 2) ? ir(SSRM_REG_MODE) : hr(SSRM_REG_MODE, 4'h0), {8'h00, mv[k]});
    end
    vso <= 16'hA5C3;
    qc("vso_word", ir(SSRM_REG_VSO), 16'hA5C3);
    qc("vso_d0", 32'd0, 16'h0001);
    qc("vso_d2", 32'd2, 16'h0000);
    q(hr(SSRM_REG_VSO, 4'h7), r);
    chk("vso_bit", {31'h0, r[16]}, 32'h1);
    @(posedge clk_in);
    swr <= 1'b1;
    schar <= 8'h53;
    @(posedge clk_in);
    sidx <= 4'h1;
    schar <= 8'h79;
    @(posedge clk_in);
    swr <= 1'b0;
    slen <= 32'h0001_0005;
    qc("len_hi", hr(SSRM_REG_LEN_HI, 4'h0), 16'h0001);
    qc("len_lo", hr(SSRM_REG_LEN_LO, 4'h0), 16'h0005);
    len16 <= 1'b1;
    qc("len_pad", ir(SSRM_REG_LEN_HI), SSRM_PAD_WORD);
    qc("len16_lo", ir(SSRM_REG_LEN_LO), 16'h0005);
    qc("str", hr(SSRM_REG_STR, 4'h0), 16'h5379);
    q({11'h0, 1'b1, 4'h3, 16'd20}, r);
    chk("asm_bit", {31'h0, r[16]}, 32'h1);
    swap <= 1'b1;
    qc("str_swap", hr(SSRM_REG_STR, 4'h0), 16'h7953);
    ip <= 32'hC0A8_0080;
    qc("ip_hi", ir(SSRM_REG_IP_HI), 16'hC0A8);
    rdr(SSRM_C_OCTET, r);
    chk("octet_hi", r, 32'h0192_0168);
    rdr(SSRM_C_HEX_HI, r);
    chk("hex_hi", r, 32'h4330_2041);
    rdr(SSRM_C_HEX_LO, r);
    chk("hex_lo", r, 32'h3800_0000);
    qc("ip_lo", ir(SSRM_REG_IP_LO), 16'h0080);
    rdr(SSRM_C_OCTET, r);
    chk("octet_lo", r, 32'h0000_0128);
    qc("reserved", hr(16'h0005, 4'h0), 16'h0000);
    rdr(SSRM_C_CMD, r);
    chk("cmd", r, hr(16'h0005, 4'h0));
    rdr(4'hF, r);
    chk("unmapped", r, 32'h0);
    // whole polling periods in a fixed span, independent of phase
    wrr(SSRM_C_CTRL, 32'h1);
    rdr(SSRM_C_CTRL, r);
    chk("ctrl", r, 32'h1);
    repeat (30) @(posedge clk_in);
    #1 npoll = 0;
    repeat (100) @(posedge clk_in);
    #1 chk("polls", 32'(npoll), 32'd5);
    wrr(SSRM_C_CTRL, 32'h0);
    give_verdict();
  end
endmodule // safety_status_register_map_bench
`default_nettype wire
